/* File: hdl/fps_map.svh */
// register offsets, reset values and field layout for the fifo partition registers
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// direct host addresses of the indirect register pair
`define FPS_IND_PTR_ADDR 8'hF8
`define FPS_IND_DATA_ADDR 8'hFC
`define FPS_QUADLET_STEP 16'h0004

// indirect offsets of the six size registers
`define FPS_OFS_ARX_RSP 16'h0100
`define FPS_OFS_ARX_REQ 16'h0104
`define FPS_OFS_ATX_RSP 16'h0110
`define FPS_OFS_ATX_REQ 16'h0114
`define FPS_OFS_ISO_RX 16'h0120
`define FPS_OFS_ISO_TX 16'h0130

// reset values of the six size registers
`define FPS_RST_ARX_RSP 32'h00000003
`define FPS_RST_ARX_REQ 32'h00000407
`define FPS_RST_ATX_RSP 32'h0000080B
`define FPS_RST_ATX_REQ 32'h00000C0F
`define FPS_RST_ISO_RX 32'h0000101F
`define FPS_RST_ISO_TX 32'h0000202F

// field positions inside a size register
`define FPS_BASE_MSB 13
`define FPS_BASE_LSB 8
`define FPS_END_MSB 5
`define FPS_END_LSB 0
`define FPS_HI_UNUSED_MSB 31
`define FPS_HI_UNUSED_LSB 14
`define FPS_MID_UNUSED_MSB 7
`define FPS_MID_UNUSED_LSB 6

// memory word address composition, one block is 64 quadlets
`define FPS_LOW_ZEROS 6'h00
`define FPS_LOW_ONES 6'h3F
`define FPS_BLK_ONE 7'h01
`define FPS_WORD_ONE 12'h001
`define FPS_FIFO_COUNT 6
`define FPS_PTR_W 16

`endif

/* File: hdl/fps_pkg.sv */
// types shared by the fifo partition register bank
`default_nettype none
package fps_pkg;
	// one size register, start and end block
	typedef struct packed {
		logic [5:0] base;
		logic [5:0] last;
	} fps_size_type;

	// derived region of one fifo in the shared memory
	typedef struct packed {
		logic [11:0] first;
		logic [11:0] last;
		logic [12:0] capacity;
	} fps_region_type;

	// write and read word pointers of one fifo
	typedef struct packed {
		logic [11:0] wr;
		logic [11:0] rd;
	} fps_ptr_type;

	// fifo index order used on every per-fifo port
	typedef enum logic [2:0] {
		FPS_ARX_RSP = 3'h0,
		FPS_ARX_REQ = 3'h1,
		FPS_ATX_RSP = 3'h2,
		FPS_ATX_REQ = 3'h3,
		FPS_ISO_RX = 3'h4,
		FPS_ISO_TX = 3'h5
	} fps_fifo_type;
endpackage
`default_nettype wire

/* File: hdl/fps_fifo_region.sv */
// region arithmetic and wrapping word pointers for one fifo
`default_nettype none
`include "fps_map.svh"
module fps_fifo_region #(
	parameter fps_pkg::fps_size_type RST_SIZE = '0
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire fps_pkg::fps_size_type size,
	input wire logic reload,
	input wire logic wr_adv,
	input wire logic rd_adv,
	output fps_pkg::fps_region_type region,
	output fps_pkg::fps_ptr_type ptr
);
	import fps_pkg::*;

	localparam logic [11:0] RST_FIRST = {RST_SIZE.base, `FPS_LOW_ZEROS};

	// start and end words come straight from the block fields
	wire logic [11:0] first_nxt = {size.base, `FPS_LOW_ZEROS};
	wire logic [11:0] last_nxt = {size.last, `FPS_LOW_ONES};
	// no range check: a reversed pair simply wraps modulo 128 in the 7-bit block count
	wire logic [6:0] blocks = {1'b0, size.last} - {1'b0, size.base} + `FPS_BLK_ONE;
	wire logic [12:0] cap_nxt = {blocks[6:0], `FPS_LOW_ZEROS};

	// pointers step by one word and fold back at the region end
	wire logic [11:0] wr_step = (ptr.wr == last_nxt) ? first_nxt : ptr.wr + `FPS_WORD_ONE;
	wire logic [11:0] rd_step = (ptr.rd == last_nxt) ? first_nxt : ptr.rd + `FPS_WORD_ONE;
	wire logic [11:0] wr_nxt = reload ? first_nxt : (wr_adv ? wr_step : ptr.wr);
	wire logic [11:0] rd_nxt = reload ? first_nxt : (rd_adv ? rd_step : ptr.rd);

	// region outputs trail the size register by one edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			region <= '{first: RST_FIRST, last: {RST_SIZE.last, `FPS_LOW_ONES},
				capacity: '0};
			ptr <= '{wr: RST_FIRST, rd: RST_FIRST};
		end else begin
			region <= '{first: first_nxt, last: last_nxt, capacity: cap_nxt};
			ptr <= '{wr: wr_nxt, rd: rd_nxt};
		end
	end

	a_wrap_back: assert property (@(posedge clk) disable iff (!arst_n)
		(!reload && wr_adv && ptr.wr == last_nxt) |=> ptr.wr == $past(first_nxt))
		else $error("write pointer did not wrap to region start");
	a_cap_blocks: assert property (@(posedge clk) disable iff (!arst_n)
		$stable(size) |=> region.capacity ==
			{7'({1'b0, $past(size.last)} - {1'b0, $past(size.base)} + 7'h01), 6'h00})
		else $error("capacity is not block count times 64");
	a_first_word: assert property (@(posedge clk) disable iff (!arst_n)
		$stable(size) |=> region.first[11:6] == $past(size.base)
			&& region.first[5:0] == 6'h00)
		else $error("first word address malformed");
	a_last_word: assert property (@(posedge clk) disable iff (!arst_n)
		$stable(size) |=> region.last[11:6] == $past(size.last)
			&& region.last[5:0] == 6'h3F)
		else $error("last word address malformed");
	c_wrap_seen: cover property (@(posedge clk) disable iff (!arst_n)
		rd_adv && ptr.rd == last_nxt);
endmodule // fps_fifo_region
`default_nettype wire

/* File: hdl/fps_config.sv */
// fifo partition register bank behind the indirect pointer and data window
`default_nettype none
`include "fps_map.svh"
module fps_config (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic hif_strobe,
	input wire logic hif_write,
	input wire logic [7:0] hif_addr,
	input wire logic [31:0] hif_wdata,
	output logic [31:0] hif_rdata,
	output logic hif_ack,
	input wire logic [5:0] fifo_wr_adv,
	input wire logic [5:0] fifo_rd_adv,
	output wire fps_pkg::fps_region_type [5:0] fifo_region,
	output wire fps_pkg::fps_ptr_type [5:0] fifo_ptr,
	output logic [15:0] indirect_pointer
);
	import fps_pkg::*;

	localparam int NFIFO = `FPS_FIFO_COUNT;

	// offset and reset tables, indexed in fps_fifo_type order
	localparam logic [15:0] OFS_TAB [NFIFO] = '{
		`FPS_OFS_ARX_RSP, `FPS_OFS_ARX_REQ, `FPS_OFS_ATX_RSP,
		`FPS_OFS_ATX_REQ, `FPS_OFS_ISO_RX, `FPS_OFS_ISO_TX
	};
	localparam logic [31:0] RST_TAB [NFIFO] = '{
		`FPS_RST_ARX_RSP, `FPS_RST_ARX_REQ, `FPS_RST_ATX_RSP,
		`FPS_RST_ATX_REQ, `FPS_RST_ISO_RX, `FPS_RST_ISO_TX
	};

	// size register storage and pending pointer reload per fifo
	// written_r only feeds the reset layout checks; once a register has been
	// written its default no longer has to hold
	fps_size_type size_r [NFIFO];
	logic [NFIFO-1:0] reload_r;
	logic [NFIFO-1:0] written_r;

	// the size registers have no direct address of their own, so a stray host
	// access can never land in them
	// direct decode: only the pointer and the data window are visible
	wire logic hit_ptr = hif_strobe && (hif_addr == `FPS_IND_PTR_ADDR);
	wire logic hit_data = hif_strobe && (hif_addr == `FPS_IND_DATA_ADDR);
	wire logic ptr_wr = hit_ptr && hif_write;
	wire logic data_wr = hit_data && hif_write;
	wire logic data_rd = hit_data && !hif_write;

	// a window access and a pointer write cannot meet in one cycle, one address
	// per strobe, so the pointer write needs no priority over the step
	// pointer advances by one quadlet on each window access
	wire logic [15:0] ptr_inc = indirect_pointer + `FPS_QUADLET_STEP;
	wire logic [15:0] ptr_nxt = ptr_wr ? hif_wdata[15:0] : (hit_data ? ptr_inc : indirect_pointer);

	// indirect decode of the pointer onto the six size registers
	logic [NFIFO-1:0] sel;
	always_comb begin
		for (int i = 0; i < NFIFO; i++) begin
			sel[i] = (indirect_pointer == OFS_TAB[i]);
		end
	end
	wire logic sel_any = |sel;

	// write enables per size register
	wire logic [NFIFO-1:0] size_we = sel & {NFIFO{data_wr}};

	// incoming write split into fields; unused bits are dropped on the floor
	wire fps_size_type wr_size = '{
		base: hif_wdata[`FPS_BASE_MSB:`FPS_BASE_LSB],
		last: hif_wdata[`FPS_END_MSB:`FPS_END_LSB]
	};

	// one-hot select, so the or-style loop never merges two registers;
	// reserved locations fall through to zero rather than aliasing a register
	// read mux: the selected register, or zero for reserved indirect space
	logic [31:0] win_rdata;
	always_comb begin
		win_rdata = '0;
		for (int i = 0; i < NFIFO; i++) begin
			if (sel[i]) begin
				win_rdata[`FPS_BASE_MSB:`FPS_BASE_LSB] = size_r[i].base;
				win_rdata[`FPS_END_MSB:`FPS_END_LSB] = size_r[i].last;
			end
		end
	end

	// read data reloads every cycle and is only meaningful with the answer;
	// keeping write answers at zero stops stale size data leaking onto the bus
	// answer word for the two direct addresses
	wire logic [31:0] ptr_rdata = {16'h0000, indirect_pointer};
	wire logic [31:0] rdata_nxt = hif_write ? '0 : (hit_ptr ? ptr_rdata : win_rdata);
	wire logic ack_nxt = hit_ptr || hit_data;

	// host answer registers; writes answer with zero data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hif_rdata <= '0;
			hif_ack <= 1'b0;
		end else begin
			hif_rdata <= rdata_nxt;
			hif_ack <= ack_nxt;
		end
	end

	// indirect pointer register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			indirect_pointer <= '0;
		end else begin
			indirect_pointer <= ptr_nxt;
		end
	end

	// size registers, one generate slice per fifo, each with its own region logic
	genvar g;
	generate
		for (g = 0; g < NFIFO; g++) begin : g_fifo
			localparam fps_size_type RST_SIZE = '{
				base: RST_TAB[g][`FPS_BASE_MSB:`FPS_BASE_LSB],
				last: RST_TAB[g][`FPS_END_MSB:`FPS_END_LSB]
			};

			// reset layout lands each fifo in its default blocks
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					size_r[g] <= RST_SIZE;
					reload_r[g] <= 1'b0;
					written_r[g] <= 1'b0;
				end else begin
					size_r[g] <= size_we[g] ? wr_size : size_r[g];
					reload_r[g] <= size_we[g];
					written_r[g] <= written_r[g] | size_we[g];
				end
			end

			// pointers restart at the new region start after a resize, since the
			// old contents are no longer addressable in a consistent way
			fps_fifo_region #(
				.RST_SIZE(RST_SIZE)
			) u_region (
				.clk(clk),
				.arst_n(arst_n),
				.size(size_r[g]),
				.reload(reload_r[g]),
				.wr_adv(fifo_wr_adv[g]),
				.rd_adv(fifo_rd_adv[g]),
				.region(fifo_region[g]),
				.ptr(fifo_ptr[g])
			);

			// per fifo checks: a window write lands in this register and nowhere else,
			// and the pointer pair answers the advance strobes one edge later
			a_size_load: assert property (@(posedge clk)
				disable iff (!arst_n) size_we[g] |=> size_r[g] == $past(wr_size))
				else $error("size register did not take the written fields");

			a_size_keep: assert property (@(posedge clk)
				disable iff (!arst_n) !size_we[g] |=> size_r[g] == $past(size_r[g]))
				else $error("size register changed without a window write");

			// a resize restarts both pointers, not just the write side
			a_reload_both: assert property (@(posedge clk)
				disable iff (!arst_n) size_we[g] |=> ##1
					fifo_ptr[g].wr == {size_r[g].base, `FPS_LOW_ZEROS}
					&& fifo_ptr[g].rd == {size_r[g].base, `FPS_LOW_ZEROS})
				else $error("resized fifo pointers did not restart together");

			// region words trail the register by one edge
			a_region_follow: assert property (@(posedge clk)
				disable iff (!arst_n) $stable(size_r[g]) |=>
					fifo_region[g].first == {$past(size_r[g].base), `FPS_LOW_ZEROS}
					&& fifo_region[g].last == {$past(size_r[g].last), `FPS_LOW_ONES})
				else $error("region words do not follow the size register");

			// an ordered region keeps both pointers inside it once the reload is done
			a_ptr_inside: assert property (@(posedge clk)
				disable iff (!arst_n) ($stable(size_r[g]) && !reload_r[g]
					&& fifo_region[g].first <= fifo_region[g].last) |->
					(fifo_ptr[g].wr >= fifo_region[g].first
					&& fifo_ptr[g].wr <= fifo_region[g].last
					&& fifo_ptr[g].rd >= fifo_region[g].first
					&& fifo_ptr[g].rd <= fifo_region[g].last))
				else $error("fifo pointer left its programmed region");

			a_rd_wrap: assert property (@(posedge clk)
				disable iff (!arst_n) (!reload_r[g] && fifo_rd_adv[g]
					&& fifo_ptr[g].rd == {size_r[g].last, `FPS_LOW_ONES}) |=>
					fifo_ptr[g].rd == {$past(size_r[g].base), `FPS_LOW_ZEROS})
				else $error("read pointer did not wrap to region start");

			a_step_one: assert property (@(posedge clk)
				disable iff (!arst_n) (!reload_r[g] && fifo_wr_adv[g]
					&& fifo_ptr[g].wr != {size_r[g].last, `FPS_LOW_ONES}) |=>
					fifo_ptr[g].wr == $past(fifo_ptr[g].wr) + `FPS_WORD_ONE)
				else $error("write pointer did not step one word");

			a_ptr_rest: assert property (@(posedge clk)
				disable iff (!arst_n) (!reload_r[g] && !fifo_wr_adv[g]) |=> $stable(fifo_ptr[g].wr))
				else $error("write pointer moved without an advance");
		end
	endgenerate

	// packed images of each register as software would read it, used only
	// by the default layout and reserved write checks
	// helper views for the checks below
	wire logic [31:0] raw0 = {18'h0, size_r[FPS_ARX_RSP].base, 2'b00, size_r[FPS_ARX_RSP].last};
	wire logic [31:0] raw1 = {18'h0, size_r[FPS_ARX_REQ].base, 2'b00, size_r[FPS_ARX_REQ].last};
	wire logic [31:0] raw2 = {18'h0, size_r[FPS_ATX_RSP].base, 2'b00, size_r[FPS_ATX_RSP].last};
	wire logic [31:0] raw3 = {18'h0, size_r[FPS_ATX_REQ].base, 2'b00, size_r[FPS_ATX_REQ].last};
	wire logic [31:0] raw4 = {18'h0, size_r[FPS_ISO_RX].base, 2'b00, size_r[FPS_ISO_RX].last};
	wire logic [31:0] raw5 = {18'h0, size_r[FPS_ISO_TX].base, 2'b00, size_r[FPS_ISO_TX].last};

	a_ptr_advance: assert property (@(posedge clk) disable iff (!arst_n)
		hit_data |=> indirect_pointer == $past(indirect_pointer) + 16'h0004)
		else $error("pointer did not advance one quadlet");

	a_ptr_load: assert property (@(posedge clk) disable iff (!arst_n)
		ptr_wr |=> indirect_pointer == $past(hif_wdata[15:0]) && hif_ack)
		else $error("pointer write not taken");

	a_direct_only: assert property (@(posedge clk) disable iff (!arst_n)
		(hif_strobe && hif_addr != 8'hF8 && hif_addr != 8'hFC) |=>
			!hif_ack && $stable(indirect_pointer))
		else $error("direct address other than the pair was answered");

	a_read_layout: assert property (@(posedge clk) disable iff (!arst_n)
		data_rd |=> hif_ack && hif_rdata[31:14] == 18'h0 && hif_rdata[7:6] == 2'b00)
		else $error("unused size register bits read nonzero");

	a_write_back: assert property (@(posedge clk) disable iff (!arst_n)
		((data_wr && sel_any)
			##2 (ptr_wr && hif_wdata[15:0] == $past(indirect_pointer, 2))
			##1 !ack_nxt ##1 data_rd) |=>
			hif_rdata == ($past(hif_wdata, 5) & 32'h00003F3F))
		else $error("size register did not read back what was written");

	a_rst_async_rx: assert property (@(posedge clk) disable iff (!arst_n)
		!written_r[0] && !written_r[1] |-> raw0 == 32'h00000003 && raw1 == 32'h00000407)
		else $error("async receive fifo default layout wrong");

	a_rst_async_tx: assert property (@(posedge clk) disable iff (!arst_n)
		!written_r[2] && !written_r[3] |-> raw2 == 32'h0000080B && raw3 == 32'h00000C0F)
		else $error("async transmit fifo default layout wrong");

	a_rst_iso: assert property (@(posedge clk) disable iff (!arst_n)
		!written_r[4] && !written_r[5] |-> raw4 == 32'h0000101F && raw5 == 32'h0000202F)
		else $error("iso fifo default layout wrong");

	a_resize_restart: assert property (@(posedge clk) disable iff (!arst_n)
		size_we[0] |=> ##1 fifo_ptr[0].wr == {size_r[0].base, 6'h00}
			&& fifo_region[0].first == {size_r[0].base, 6'h00})
		else $error("resized fifo did not restart at its new region");

	a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
		(data_rd && !sel_any) |=> hif_rdata == 32'h0)
		else $error("reserved indirect location read nonzero");

	// bus answer: exactly one answer per decoded strobe, on the next edge, and
	// the pointer only moves for the pair; these catch a stuck or doubled ack
	a_ack_next: assert property (@(posedge clk) disable iff (!arst_n)
		ack_nxt |=> hif_ack)
		else $error("decoded access not answered on the next edge");

	a_ack_only: assert property (@(posedge clk) disable iff (!arst_n)
		!ack_nxt |=> !hif_ack)
		else $error("answer without a decoded access");

	a_ptr_readback: assert property (@(posedge clk) disable iff (!arst_n)
		(hit_ptr && !hif_write) |=> hif_rdata == {16'h0000, $past(indirect_pointer)})
		else $error("pointer read did not return the pointer");

	a_write_quiet: assert property (@(posedge clk) disable iff (!arst_n)
		(ack_nxt && hif_write) |=> hif_rdata == 32'h00000000)
		else $error("write answer carried data");

	a_ptr_idle: assert property (@(posedge clk) disable iff (!arst_n)
		!ack_nxt |=> $stable(indirect_pointer))
		else $error("pointer moved without a pair access");

	a_reserved_keep: assert property (@(posedge clk) disable iff (!arst_n)
		(data_wr && !sel_any) |=> $stable(raw0) && $stable(raw1) && $stable(raw2)
			&& $stable(raw3) && $stable(raw4) && $stable(raw5))
		else $error("reserved indirect write changed a size register");

	// main scenarios to reach
	c_burst_write: cover property (@(posedge clk) disable iff (!arst_n)
		data_wr ##2 data_wr ##2 data_wr);
	c_read_size: cover property (@(posedge clk) disable iff (!arst_n)
		data_rd && sel[FPS_ISO_TX]);
	c_reversed: cover property (@(posedge clk) disable iff (!arst_n)
		size_we[FPS_ARX_REQ] && wr_size.last < wr_size.base);
	c_ptr_then_read: cover property (@(posedge clk) disable iff (!arst_n)
		ptr_wr ##2 data_rd);
endmodule // fps_config
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the fifo partition register bank
`default_nettype none
`include "fps_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import fps_pkg::*;

	logic clk;
	logic arst_n;
	logic hif_strobe;
	logic hif_write;
	logic [7:0] hif_addr;
	logic [31:0] hif_wdata;
	logic [31:0] hif_rdata;
	logic hif_ack;
	logic [5:0] fifo_wr_adv;
	logic [5:0] fifo_rd_adv;
	fps_region_type [5:0] fifo_region;
	fps_ptr_type [5:0] fifo_ptr;
	logic [15:0] indirect_pointer;
	logic [31:0] rd_val;
	int err_count;
	int n_compared;

	// size register offsets and reset values in fifo index order
	localparam logic [15:0] OFS [6] = '{`FPS_OFS_ARX_RSP, `FPS_OFS_ARX_REQ, `FPS_OFS_ATX_RSP,
		`FPS_OFS_ATX_REQ, `FPS_OFS_ISO_RX, `FPS_OFS_ISO_TX};
	localparam logic [31:0] RST [6] = '{`FPS_RST_ARX_RSP, `FPS_RST_ARX_REQ, `FPS_RST_ATX_RSP,
		`FPS_RST_ATX_REQ, `FPS_RST_ISO_RX, `FPS_RST_ISO_TX};

	fps_config dut_u (.clk(clk), .arst_n(arst_n), .hif_strobe(hif_strobe),
		.hif_write(hif_write), .hif_addr(hif_addr), .hif_wdata(hif_wdata),
		.hif_rdata(hif_rdata), .hif_ack(hif_ack), .fifo_wr_adv(fifo_wr_adv),
		.fifo_rd_adv(fifo_rd_adv), .fifo_region(fifo_region), .fifo_ptr(fifo_ptr),
		.indirect_pointer(indirect_pointer));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// one compare for every value seen at the ports
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one host access; starts on a fresh edge so strobe is never reassigned in one step
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data,
		input logic exp_ack);
		@(posedge clk);
		#1;
		hif_strobe = 1'b1;
		hif_write = wr;
		hif_addr = addr;
		hif_wdata = data;
		@(posedge clk);
		#1;
		hif_strobe = 1'b0;
		chk("ack", {31'h0, exp_ack}, {31'h0, hif_ack});
		rd_val = hif_rdata;
	endtask

	// expected region and reloaded pointers of fifo g for size register value sz
	task automatic chk_region(input int g, input logic [31:0] sz);
		logic [12:0] cap;
		cap = {7'(sz[5:0]) - 7'(sz[13:8]) + 7'h01, 6'h00};
		chk("first", {20'h0, sz[13:8], 6'h00}, {20'h0, fifo_region[g].first});
		chk("last", {20'h0, sz[5:0], 6'h3F}, {20'h0, fifo_region[g].last});
		chk("capacity", {19'h0, cap}, {19'h0, fifo_region[g].capacity});
		chk("wr ptr", {20'h0, sz[13:8], 6'h00}, {20'h0, fifo_ptr[g].wr});
		chk("rd ptr", {20'h0, sz[13:8], 6'h00}, {20'h0, fifo_ptr[g].rd});
	endtask

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// watchdog: the tests need a few hundred cycles at most
	initial begin
		#40000;
		err_count++;
		finish_test();
	end

	initial begin
		err_count = 0;
		n_compared = 0;
		arst_n = 1'b0;
		hif_strobe = 1'b0;
		hif_write = 1'b0;
		hif_addr = 8'h00;
		hif_wdata = 32'h00000000;
		fifo_wr_adv = 6'h00;
		fifo_rd_adv = 6'h00;
		repeat (20) @(posedge clk);
		#1;
		arst_n = 1'b1;
		// reset values read back through the indirect pair, regions follow
		for (int g = 0; g < 6; g++) begin
			bus(1'b1, `FPS_IND_PTR_ADDR, {16'h0, OFS[g]}, 1'b1);
			bus(1'b0, `FPS_IND_DATA_ADDR, 32'h0, 1'b1);
			chk("reset value", RST[g], rd_val);
			chk_region(g, RST[g]);
		end
		$display("test reset values done");
		// auto-increment runs across a reserved hole without rewriting the pointer
		bus(1'b1, `FPS_IND_PTR_ADDR, 32'h00000100, 1'b1);
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, `FPS_IND_DATA_ADDR, 32'h0, 1'b1);
			chk("incr read", (i < 2) ? RST[i] : ((i == 4) ? RST[2] : 32'h0), rd_val);
		end
		chk("pointer", 32'h00000114, {16'h0, indirect_pointer});
		$display("test auto increment done");
		// unused bits dropped, reversed fields kept, reserved write ignored
		bus(1'b1, `FPS_IND_PTR_ADDR, 32'h00000100, 1'b1);
		bus(1'b1, `FPS_IND_DATA_ADDR, 32'hFFFFC5C9, 1'b1);
		bus(1'b1, `FPS_IND_DATA_ADDR, 32'h00000A05, 1'b1);
		bus(1'b1, `FPS_IND_DATA_ADDR, 32'hFFFFFFFF, 1'b1);
		chk("pointer", 32'h0000010C, {16'h0, indirect_pointer});
		bus(1'b1, `FPS_IND_PTR_ADDR, 32'h00000100, 1'b1);
		bus(1'b0, `FPS_IND_DATA_ADDR, 32'h0, 1'b1);
		chk("masked size", 32'h00000509, rd_val);
		bus(1'b0, `FPS_IND_DATA_ADDR, 32'h0, 1'b1);
		chk("reversed size", 32'h00000A05, rd_val);
		bus(1'b0, `FPS_IND_DATA_ADDR, 32'h0, 1'b1);
		chk("reserved", 32'h00000000, rd_val);
		chk_region(0, 32'h00000509);
		chk_region(1, 32'h00000A05);
		$display("test size write done");
		// a direct address outside the pair is not answered and changes nothing
		bus(1'b1, 8'h00, 32'h00000100, 1'b0);
		bus(1'b0, 8'hF0, 32'h0, 1'b0);
		chk("pointer", 32'h0000010C, {16'h0, indirect_pointer});
		bus(1'b0, `FPS_IND_PTR_ADDR, 32'h0, 1'b1);
		chk("pointer read", 32'h0000010C, rd_val);
		$display("test unmapped access done");
		// write a size register, rewind the pointer, read it back
		bus(1'b1, `FPS_IND_PTR_ADDR, {16'h0, OFS[5]}, 1'b1);
		bus(1'b1, `FPS_IND_DATA_ADDR, 32'h00003035, 1'b1);
		bus(1'b1, `FPS_IND_PTR_ADDR, {16'h0, OFS[5]}, 1'b1);
		bus(1'b0, `FPS_IND_DATA_ADDR, 32'h0, 1'b1);
		chk("iso tx size", 32'h00003035, rd_val);
		chk_region(5, 32'h00003035);
		$display("test window round trip done");
		// fifo 0 now spans 0x140..0x27F, 320 words: walk both pointers round
		@(posedge clk);
		#1;
		fifo_wr_adv = 6'h01;
		fifo_rd_adv = 6'h01;
		repeat (319) @(posedge clk);
		#1;
		chk("wr at last", 32'h0000027F, {20'h0, fifo_ptr[0].wr});
		chk("rd at last", 32'h0000027F, {20'h0, fifo_ptr[0].rd});
		@(posedge clk);
		#1;
		fifo_wr_adv = 6'h00;
		chk("wr wrapped", 32'h00000140, {20'h0, fifo_ptr[0].wr});
		chk("rd wrapped", 32'h00000140, {20'h0, fifo_ptr[0].rd});
		@(posedge clk);
		#1;
		fifo_rd_adv = 6'h00;
		chk("rd step", 32'h00000141, {20'h0, fifo_ptr[0].rd});
		chk("other fifo", 32'h00000280, {20'h0, fifo_ptr[1].wr});
		$display("test pointer wrap done");
		finish_test();
	end
endmodule // tb
`default_nettype wire
